// >>> src/ncao_regs.svh
// Offsets, field positions and timing counts of the column operation host controller.
`ifndef NCAO_REGS_SVH
`define NCAO_REGS_SVH
`define NCAO_REG_CTRL 8'h00
`define NCAO_REG_COL 8'h04
`define NCAO_REG_ROW 8'h08
`define NCAO_REG_STAT 8'h0C
`define NCAO_REG_WDATA 8'h10
`define NCAO_REG_RDATA 8'h14
`define NCAO_REG_CFG 8'h18
`define NCAO_CTRL_OP_LSB 0
`define NCAO_CTRL_OP_W 3
`define NCAO_CTRL_LEN_LSB 8
`define NCAO_CTRL_LEN_W 12
`define NCAO_CTRL_INTERLEAVE_BIT 4
`define NCAO_STAT_BUSY_BIT 0
`define NCAO_STAT_DONE_BIT 1
`define NCAO_STAT_ERR_BIT 2
`define NCAO_STAT_RDY_LSB 8
`define NCAO_SR_CACHE_RDY_BIT 6
`define NCAO_SR_ARRAY_RDY_BIT 5
`define NCAO_OPC_READ_MODE 8'h00
`define NCAO_OPC_RAND_READ 8'h05
`define NCAO_OPC_RAND_READ_2P 8'h06
`define NCAO_OPC_CONFIRM_RD 8'hE0
`define NCAO_OPC_RAND_INPUT 8'h85
`define NCAO_OPC_PAGE_READ_GO 8'h30
`define NCAO_OPC_STATUS 8'h70
`define NCAO_OPC_STATUS_ENH 8'h78
`define NCAO_CLK_PERIOD_PS 5000
`define NCAO_WHR_NS 60
`define NCAO_ADL_NS 70
`define NCAO_STROBE_NS 15
`define NCAO_WHR_CYC ((`NCAO_WHR_NS * 1000 + `NCAO_CLK_PERIOD_PS - 1) / `NCAO_CLK_PERIOD_PS)
`define NCAO_ADL_CYC ((`NCAO_ADL_NS * 1000 + `NCAO_CLK_PERIOD_PS - 1) / `NCAO_CLK_PERIOD_PS)
`define NCAO_STROBE_CYC ((`NCAO_STROBE_NS * 1000 + `NCAO_CLK_PERIOD_PS - 1) / `NCAO_CLK_PERIOD_PS)
`endif

// >>> src/ncao_pkg.sv
// Types shared by the column operation host controller.
package ncao_pkg;
    typedef enum logic [2:0] {
        NCAO_OP_RAND_READ = 3'h0,
        NCAO_OP_RAND_READ_2P = 3'h1,
        NCAO_OP_INPUT_SHORT = 3'h2,
        NCAO_OP_INPUT_LONG = 3'h3,
        NCAO_OP_PAGE_READ = 3'h4
    } ncao_op_t;

    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
    } ncao_strobe_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } ncao_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } ncao_axi_rsp_t;
endpackage : ncao_pkg

// >>> src/ncao_buf.sv
// Small byte buffer for page data moved over the flash bus.
`timescale 1ns/1ps
module ncao_buf #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic aclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : ncao_buf

// >>> src/ncao_host.sv
// Host controller issuing column address operations to a flash die.
`timescale 1ns/1ps
`include "ncao_regs.svh"
module ncao_host import ncao_pkg::*; #(
    parameter int COL_W = 12,
    parameter int ROW_W = 24,
    parameter int BUF_AW = 6
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus.
    input wire ncao_axi_req_t axi_req,
    output ncao_axi_rsp_t axi_rsp,
    // Flash pins.
    output ncao_strobe_t nf_strobe_q,
    output logic [7:0] nf_io_o_q,
    output logic nf_io_oe_q,
    input wire logic [7:0] nf_io_i,
    input wire logic nf_ready_busy_n
);
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_PRE = 8'h02,
        ST_CMD = 8'h04,
        ST_ADDR = 8'h08,
        ST_CONF = 8'h10,
        ST_WAIT = 8'h20,
        ST_DATA = 8'h40,
        ST_POLL = 8'h80
    } ncao_st_t;

    localparam int WHR_CYC = `NCAO_WHR_CYC;
    localparam int ADL_CYC = `NCAO_ADL_CYC;
    localparam int STB_CYC = `NCAO_STROBE_CYC;

    // Software registers.
    ncao_op_t op_q, op_d;
    logic interleave_q, interleave_d;
    logic [11:0] len_q, len_d;
    logic [COL_W-1:0] col_q, col_d;
    logic [ROW_W-1:0] row_q, row_d;
    logic [7:0] sr_q, sr_d;
    logic busy_q, busy_d, done_q, done_d, err_q, err_d;
    logic start;
    // Sequencer.
    ncao_st_t st_q, st_d;
    logic [2:0] step_q, step_d;
    logic [3:0] tick_q, tick_d;
    logic [7:0] wait_q, wait_d;
    logic [11:0] cnt_q, cnt_d;
    logic phase_q, phase_d;
    ncao_strobe_t stb_d;
    logic [7:0] io_d;
    logic oe_d;
    logic pre_done_q, pre_done_d;
    // Buffer.
    logic buf_we;
    logic [BUF_AW-1:0] buf_waddr, buf_raddr;
    logic [7:0] buf_wdata, buf_rdata;
    // Bus slave.
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic wr_fire;

    ncao_buf #(.DEPTH(1 << BUF_AW), .AW(BUF_AW)) u_buf (
        .aclk(aclk),
        .we(buf_we),
        .waddr(buf_waddr),
        .wdata(buf_wdata),
        .raddr(buf_raddr),
        .rdata(buf_rdata)
    );

    // Write address and data are latched independently; the write happens once both are held.
    assign wr_fire = aw_q && w_q && !bv_q;
    assign start = wr_fire && awa_q == `NCAO_REG_CTRL && !busy_q;

    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        bv_d = bv_q;
        rv_d = rv_q;
        awa_d = awa_q;
        wd_d = wd_q;
        rd_d = rd_q;
        bresp_d = bresp_q;
        rresp_d = rresp_q;
        if (axi_req.awvalid && !aw_q) begin
            aw_d = 1'b1;
            awa_d = axi_req.awaddr[7:0];
        end
        if (axi_req.wvalid && !w_q) begin
            w_d = 1'b1;
            wd_d = axi_req.wdata;
        end
        if (wr_fire) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            bresp_d = (awa_q <= `NCAO_REG_CFG && awa_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
            if (awa_q == `NCAO_REG_CTRL && busy_q) begin
                bresp_d = 2'h2;
            end
        end
        if (bv_q && axi_req.bready) begin
            bv_d = 1'b0;
        end
        if (axi_req.arvalid && !rv_q) begin
            rv_d = 1'b1;
            rresp_d = 2'h0;
            case (axi_req.araddr[7:0])
                `NCAO_REG_CTRL: rd_d = {12'h000, len_q, 3'h0, interleave_q, 1'b0, op_q};
                `NCAO_REG_COL: rd_d = 32'(col_q);
                `NCAO_REG_ROW: rd_d = 32'(row_q);
                `NCAO_REG_STAT: rd_d = {16'h0000, sr_q, 5'h00, err_q, done_q, busy_q};
                `NCAO_REG_RDATA: rd_d = {24'h000000, buf_rdata};
                default: begin
                    rd_d = 32'h00000000;
                    rresp_d = 2'h2;
                end
            endcase
        end
        if (rv_q && axi_req.rready) begin
            rv_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h00000000;
            rd_q <= 32'h00000000;
            bresp_q <= 2'h0;
            rresp_q <= 2'h0;
        end else begin
            aw_q <= aw_d;
            w_q <= w_d;
            bv_q <= bv_d;
            rv_q <= rv_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
        end
    end

    always_comb begin
        axi_rsp.awready = !aw_q;
        axi_rsp.wready = !w_q;
        axi_rsp.bvalid = bv_q;
        axi_rsp.bresp = bresp_q;
        axi_rsp.arready = !rv_q;
        axi_rsp.rvalid = rv_q;
        axi_rsp.rdata = rd_q;
        axi_rsp.rresp = rresp_q;
    end

    // Buffer: software fills it for input; the flash fills it during output.
    assign buf_we = (wr_fire && awa_q == `NCAO_REG_WDATA) || (st_q == ST_DATA && !op_q[1] && phase_q
        && tick_q == 4'(STB_CYC));
    assign buf_waddr = wr_fire ? wd_q[8 +: BUF_AW] : cnt_q[BUF_AW-1:0];
    assign buf_wdata = wr_fire ? wd_q[7:0] : nf_io_i;
    assign buf_raddr = (st_q == ST_DATA) ? cnt_q[BUF_AW-1:0] : axi_req.araddr[8 +: BUF_AW];

    // Command sequencer, a command or address strobe is STB_CYC low then STB_CYC high; a data strobe is STB_CYC low then STB_CYC+1 high.
    always_comb begin
        op_d = op_q;
        interleave_d = interleave_q;
        len_d = len_q;
        col_d = col_q;
        row_d = row_q;
        sr_d = sr_q;
        busy_d = busy_q;
        done_d = done_q;
        err_d = err_q;
        st_d = st_q;
        step_d = step_q;
        tick_d = tick_q;
        wait_d = wait_q;
        cnt_d = cnt_q;
        phase_d = phase_q;
        pre_done_d = pre_done_q;
        stb_d = nf_strobe_q;
        io_d = nf_io_o_q;
        oe_d = nf_io_oe_q;
        if (wr_fire && awa_q == `NCAO_REG_COL && !busy_q) begin
            col_d = wd_q[COL_W-1:0];
        end
        if (wr_fire && awa_q == `NCAO_REG_ROW && !busy_q) begin
            row_d = wd_q[ROW_W-1:0];
        end
        if (wr_fire && awa_q == `NCAO_REG_STAT) begin
            done_d = done_q & ~wd_q[`NCAO_STAT_DONE_BIT];
            err_d = err_q & ~wd_q[`NCAO_STAT_ERR_BIT];
        end
        if (start) begin
            op_d = ncao_op_t'(wd_q[`NCAO_CTRL_OP_LSB +: `NCAO_CTRL_OP_W]);
            interleave_d = wd_q[`NCAO_CTRL_INTERLEAVE_BIT];
            len_d = wd_q[`NCAO_CTRL_LEN_LSB +: `NCAO_CTRL_LEN_W];
            busy_d = 1'b1;
            step_d = 3'h0;
            tick_d = 4'h0;
            phase_d = 1'b0;
            pre_done_d = 1'b0;
            // Interleaved dies need enhanced status select first to avoid bus contention.
            st_d = wd_q[`NCAO_CTRL_INTERLEAVE_BIT] ? ST_PRE : ST_POLL;
        end
        case (st_q)
            ST_IDLE: begin
                stb_d = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1};
                oe_d = 1'b0;
            end
            ST_PRE, ST_CMD, ST_ADDR, ST_CONF: begin
                stb_d.ce_n = 1'b0;
                // A status read hands over with the read strobe still low, so it is lifted here.
                stb_d.re_n = 1'b1;
                stb_d.cle = (st_q != ST_ADDR) && !(st_q == ST_PRE && step_q != 3'h0);
                stb_d.ale = !stb_d.cle;
                oe_d = 1'b1;
                if (st_q == ST_PRE) begin
                    io_d = (step_q == 3'h0) ? `NCAO_OPC_STATUS_ENH : row_q[8*(step_q-3'h1) +: 8];
                end else if (st_q == ST_CMD) begin
                    case (op_q)
                        NCAO_OP_RAND_READ: io_d = `NCAO_OPC_RAND_READ;
                        NCAO_OP_RAND_READ_2P: io_d = `NCAO_OPC_RAND_READ_2P;
                        NCAO_OP_PAGE_READ: io_d = `NCAO_OPC_READ_MODE;
                        default: io_d = `NCAO_OPC_RAND_INPUT;
                    endcase
                end else if (st_q == ST_ADDR) begin
                    // Column low byte first, upper unused bits sent as zero.
                    io_d = (step_q == 3'h0) ? col_q[7:0] : (step_q == 3'h1) ? 8'(col_q[COL_W-1:8])
                        : row_q[8*(step_q-3'h2) +: 8];
                end else begin
                    io_d = (op_q == NCAO_OP_PAGE_READ) ? `NCAO_OPC_PAGE_READ_GO : `NCAO_OPC_CONFIRM_RD;
                end
                stb_d.we_n = (tick_q >= 4'(STB_CYC));
                tick_d = tick_q + 4'h1;
                if (tick_q == 4'(2 * STB_CYC - 1)) begin
                    tick_d = 4'h0;
                    step_d = step_q + 3'h1;
                    if (st_q == ST_PRE && step_q == 3'h3) begin
                        pre_done_d = 1'b1;
                        st_d = ST_POLL;
                        // 78h leaves the die in status output; a 70h here would wake every die.
                        step_d = 3'h1;
                    end else if (st_q == ST_CMD) begin
                        st_d = ST_ADDR;
                        step_d = 3'h0;
                    end else if (st_q == ST_ADDR) begin
                        // Two column cycles, or five with the row for 06h, long 85h and page read.
                        if (step_q == ((op_q == NCAO_OP_RAND_READ || op_q == NCAO_OP_INPUT_SHORT) ? 3'h1 : 3'h4)) begin
                            if (op_q[1] && op_q != NCAO_OP_PAGE_READ) begin
                                st_d = ST_WAIT;
                                wait_d = 8'(ADL_CYC);
                            end else begin
                                st_d = ST_CONF;
                            end
                            step_d = 3'h0;
                        end
                    end else if (st_q == ST_CONF) begin
                        st_d = (op_q != NCAO_OP_PAGE_READ) ? ST_WAIT : interleave_q ? ST_PRE : ST_POLL;
                        step_d = 3'h0;
                        wait_d = 8'(WHR_CYC);
                        phase_d = (op_q == NCAO_OP_PAGE_READ);
                    end
                end
            end
            ST_POLL: begin
                // Reads status and checks the die can take the chosen command.
                stb_d.ce_n = 1'b0;
                stb_d.cle = (tick_q < 4'(2 * STB_CYC)) && step_q == 3'h0;
                stb_d.ale = 1'b0;
                oe_d = step_q == 3'h0;
                io_d = `NCAO_OPC_STATUS;
                stb_d.we_n = !(step_q == 3'h0 && tick_q < 4'(STB_CYC));
                stb_d.re_n = !(step_q == 3'h1 && tick_q < 4'(STB_CYC));
                tick_d = tick_q + 4'h1;
                if (step_q == 3'h0 && tick_q == 4'(2 * STB_CYC - 1)) begin
                    step_d = 3'h1;
                    tick_d = 4'h0;
                end else if (step_q == 3'h1 && tick_q == 4'(STB_CYC - 1)) begin
                    sr_d = nf_io_i;
                    if (phase_q) begin
                        // Page load finished once the whole die is ready again.
                        if (nf_io_i[`NCAO_SR_ARRAY_RDY_BIT] && nf_ready_busy_n) begin
                            st_d = ST_CMD;
                            op_d = NCAO_OP_RAND_READ;
                            phase_d = 1'b0;
                        end
                    end else if (!nf_io_i[`NCAO_SR_CACHE_RDY_BIT]) begin
                        st_d = ST_POLL;
                    end else if (op_q == NCAO_OP_RAND_READ_2P && !nf_io_i[`NCAO_SR_ARRAY_RDY_BIT]) begin
                        err_d = 1'b1;
                        busy_d = 1'b0;
                        st_d = ST_IDLE;
                    end else begin
                        st_d = ST_CMD;
                    end
                    step_d = 3'h0;
                    tick_d = 4'h0;
                    // A shared bus is only polled through 78h, so each retry selects the die again.
                    if (interleave_q && st_d == ST_POLL) begin
                        st_d = ST_PRE;
                    end
                end
            end
            ST_WAIT: begin
                stb_d.cle = 1'b0;
                stb_d.ale = 1'b0;
                stb_d.we_n = 1'b1;
                wait_d = wait_q - 8'h01;
                if (wait_q == 8'h01) begin
                    st_d = ST_DATA;
                    cnt_d = 12'h000;
                    tick_d = 4'h0;
                    phase_d = 1'b0;
                    oe_d = op_q[1];
                end
            end
            ST_DATA: begin
                // Output mode holds until the next command; input bytes land from the set column.
                tick_d = tick_q + 4'h1;
                phase_d = (tick_q < 4'(STB_CYC));
                if (op_q[1]) begin
                    io_d = buf_rdata;
                    stb_d.we_n = !(tick_q >= 4'h1 && tick_q <= 4'(STB_CYC));
                end else begin
                    stb_d.re_n = !(tick_q < 4'(STB_CYC));
                end
                if (len_q == 12'h000 || (tick_q == 4'(2 * STB_CYC) && cnt_q == len_q - 12'h001)) begin
                    st_d = ST_IDLE;
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end else if (tick_q == 4'(2 * STB_CYC)) begin
                    cnt_d = cnt_q + 12'h001;
                    tick_d = 4'h0;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_q <= NCAO_OP_RAND_READ;
            interleave_q <= 1'b0;
            len_q <= 12'h000;
            col_q <= '0;
            row_q <= '0;
            sr_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            st_q <= ST_IDLE;
            step_q <= 3'h0;
            tick_q <= 4'h0;
            wait_q <= 8'h00;
            cnt_q <= 12'h000;
            phase_q <= 1'b0;
            pre_done_q <= 1'b0;
            nf_strobe_q <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1};
            nf_io_o_q <= 8'h00;
            nf_io_oe_q <= 1'b0;
        end else begin
            op_q <= op_d;
            interleave_q <= interleave_d;
            len_q <= len_d;
            col_q <= col_d;
            row_q <= row_d;
            sr_q <= sr_d;
            busy_q <= busy_d;
            done_q <= done_d;
            err_q <= err_d;
            st_q <= st_d;
            step_q <= step_d;
            tick_q <= tick_d;
            wait_q <= wait_d;
            cnt_q <= cnt_d;
            phase_q <= phase_d;
            pre_done_q <= pre_done_d;
            nf_strobe_q <= stb_d;
            nf_io_o_q <= io_d;
            nf_io_oe_q <= oe_d;
        end
    end

    sequence confirm_s;
        st_q == ST_CONF && op_q != NCAO_OP_PAGE_READ;
    endsequence
    property whr_gap_p;
        @(posedge aclk) disable iff (!aresetn) confirm_s ##1 st_q == ST_WAIT |-> nf_strobe_q.re_n [*8];
    endproperty
    read_delay_a: assert property (whr_gap_p) else $error("read strobe inside confirm wait");
    adl_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(st_q == ST_WAIT) && op_q[1] |-> nf_strobe_q.we_n [*8]) else $error("data too early");
    two_plane_ready_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == ST_POLL && st_d == ST_CMD && op_q == NCAO_OP_RAND_READ_2P && !phase_q
        |-> nf_io_i[`NCAO_SR_ARRAY_RDY_BIT]) else $error("06h issued while not ready");
    cache_ready_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == ST_POLL && st_d == ST_CMD && !phase_q |-> nf_io_i[`NCAO_SR_CACHE_RDY_BIT])
        else $error("command issued while cache busy");
    enh_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q != ST_CMD ##1 st_q == ST_CMD && interleave_q |-> pre_done_q) else $error("no 78h first");
    col_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == ST_ADDR && step_q == 3'h0 && nf_io_oe_q && tick_q == 4'h1 |-> nf_io_o_q == col_q[7:0])
        else $error("column low byte not first");
    short_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == ST_ADDR && op_q == NCAO_OP_RAND_READ |-> step_q <= 3'h1) else $error("extra address");
    done_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(done_q) |-> !busy_q && st_q == ST_IDLE) else $error("done while busy");
endmodule : ncao_host

// >>> sim/ncao_die.sv
// Behavioural flash die that answers column address operations.
`timescale 1ns/1ps
`include "ncao_regs.svh"
module ncao_die import ncao_pkg::*; (
    // Flash pins, io_w is the resolved data bus.
    input wire ncao_strobe_t stb,
    input wire logic [7:0] io_w,
    output logic [7:0] io_m,
    output logic rb_n,
    // Die state chosen by the bench.
    input wire logic array_ready_flag,
    input wire logic cache_ready_flag,
    input wire logic multi_die,
    output int faults
);
    logic [7:0] cache [4096];
    logic [7:0] cmd;
    logic [7:0] prev;
    logic [11:0] col;
    logic [23:0] row;
    logic [23:0] prog_row;
    logic out_m;
    logic in_m;
    logic sel;
    int acnt;
    realtime t_cfm;
    realtime t_adr;
    assign rb_n = cache_ready_flag;
    initial begin
        faults = 0;
        acnt = 0;
        out_m = 1'b0;
        in_m = 1'b0;
        sel = 1'b0;
        cmd = 8'hFF;
        io_m = 8'h5A;
    end
    always @(posedge stb.we_n) begin
        if (!stb.ce_n && stb.cle) begin
            prev = cmd;
            cmd = io_w;
            out_m = 1'b0;
            in_m = 1'b0;
            acnt = (io_w == 8'h78) ? 2 : 0;
            if ((io_w == 8'h05 || io_w == 8'h06) && multi_die && !sel) faults++;
            if (io_w == 8'h70 && multi_die) faults++;
            sel = sel | (io_w == 8'h78);
            if (io_w == 8'h85 && !cache_ready_flag) faults++;
            if (io_w == 8'h30 || io_w == 8'h35) begin
                for (int i = 0; i < 4096; i++) cache[i] = 8'(i) ^ row[7:0];
                out_m = 1'b1;
            end
            if (io_w == 8'hE0) begin
                t_cfm = $realtime;
                out_m = (prev == 8'h05) ? cache_ready_flag : (cache_ready_flag & array_ready_flag);
                if (!out_m) faults++;
            end
        end else if (!stb.ce_n && stb.ale) begin
            if (acnt == 0) col[7:0] = io_w;
            if (acnt == 1) col[11:8] = io_w[3:0];
            if (acnt == 1 && io_w[7:4] != 4'h0) faults++;
            if (acnt >= 2 && acnt < 5) row[8*(acnt-2)+:8] = io_w;
            acnt++;
            t_adr = $realtime;
            in_m = (cmd == 8'h85) && (acnt == 2 || acnt == 5);
            if (in_m && acnt == 5) prog_row = row;
        end else if (!stb.ce_n && in_m) begin
            if ($realtime - t_adr < `NCAO_ADL_NS) faults++;
            cache[col] = io_w;
            col++;
        end
    end
    always @(negedge stb.re_n) begin
        if (out_m && $realtime - t_cfm < `NCAO_WHR_NS) faults++;
        io_m = out_m ? cache[col] : {1'b1, cache_ready_flag, array_ready_flag, 5'h00};
        col = col + 12'(out_m);
    end
    // The bus has no pull, so a released line shows the inverse of its last value.
    always @(posedge stb.re_n) io_m = ~io_m;
endmodule : ncao_die

// >>> sim/tb_top.sv
// Self-checking bench for the column operation host controller.
`timescale 1ns/1ps
`include "ncao_regs.svh"
module tb_top import ncao_pkg::*; ;
    logic aclk;
    logic aresetn;
    ncao_axi_req_t req;
    ncao_axi_rsp_t rsp;
    ncao_strobe_t stb;
    logic [7:0] io_o;
    logic [7:0] io_m;
    logic [7:0] io_w;
    logic io_oe;
    logic rb_n;
    logic array_rdy;
    logic cache_rdy;
    logic multi_die;
    int faults;
    int mismatches;
    int compares;
    logic [31:0] st;
    logic [31:0] d;
    logic [1:0] r;
    assign io_w = io_oe ? io_o : io_m;
    ncao_host ncao_host_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .nf_strobe_q(stb),
        .nf_io_o_q(io_o), .nf_io_oe_q(io_oe), .nf_io_i(io_w), .nf_ready_busy_n(rb_n));
    ncao_die ncao_die_i (.stb(stb), .io_w(io_w), .io_m(io_m), .rb_n(rb_n), .array_ready_flag(array_rdy),
        .cache_ready_flag(cache_rdy), .multi_die(multi_die), .faults(faults));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic axw(input logic [7:0] off, input logic [31:0] dat, output logic [1:0] resp);
        req.awaddr <= {24'h0, off};
        req.wdata <= dat;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        resp = rsp.bresp;
    endtask : axw
    task automatic axr(input logic [7:0] off, input logic [5:0] idx, output logic [31:0] dat, output logic [1:0] resp);
        req.araddr <= {18'h0, idx, off};
        req.arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        dat = rsp.rdata;
        resp = rsp.rresp;
    endtask : axr
    task automatic wait_done;
        st = 32'h1;
        for (int i = 0; i < 4000 && st[0] !== 1'b0; i++) axr(`NCAO_REG_STAT, 6'h0, st, r);
        chk(st & 32'h1, 32'h0);
        axw(`NCAO_REG_STAT, 32'h6, r);
    endtask : wait_done
    task automatic run(input logic [31:0] ctrl, input logic [31:0] col, input logic [31:0] row);
        axw(`NCAO_REG_COL, col, r);
        axw(`NCAO_REG_ROW, row, r);
        axw(`NCAO_REG_CTRL, ctrl, r);
        wait_done();
    endtask : run
    task automatic put(input logic [5:0] idx, input logic [7:0] b);
        axw(`NCAO_REG_WDATA, {18'h0, idx, b}, r);
    endtask : put
    // Buffer reads come back one access late, so each index is read twice.
    task automatic get(input logic [5:0] idx, input logic [7:0] exp);
        axr(`NCAO_REG_RDATA, idx, d, r);
        axr(`NCAO_REG_RDATA, idx, d, r);
        chk(d & 32'hFF, {24'h0, exp});
    endtask : get
    task automatic t_input;
        put(6'h0, 8'h3C);
        put(6'h1, 8'hC3);
        run(32'h0000_0202, 32'hFFE, 32'h0);
        chk(st & 32'hFFFF, 32'hE002);
        chk(32'(ncao_die_i.cache[12'hFFE]), 32'h3C);
        chk(32'(ncao_die_i.cache[12'hFFF]), 32'hC3);
        put(6'h0, 8'h11);
        run(32'h0000_0103, 32'h010, 32'h123456);
        chk(32'(ncao_die_i.prog_row), 32'h123456);
        chk(32'(ncao_die_i.cache[12'h010]), 32'h11);
    endtask : t_input
    task automatic t_rand_read;
        cache_rdy <= 1'b0;
        array_rdy <= 1'b0;
        fork
            run(32'h0000_0200, 32'hFFE, 32'h0);
            begin
                repeat (300) @(posedge aclk);
                cache_rdy <= 1'b1;
            end
        join
        chk(st & 32'hFFFF, 32'hC002);
        get(6'h0, 8'h3C);
        get(6'h1, 8'hC3);
        array_rdy <= 1'b1;
    endtask : t_rand_read
    task automatic t_two_plane;
        run(32'h0000_0101, 32'h010, 32'h000040);
        chk(st & 32'h7, 32'h2);
        get(6'h0, 8'h11);
        array_rdy <= 1'b0;
        run(32'h0000_0101, 32'h010, 32'h000040);
        chk(st & 32'h5, 32'h4);
        array_rdy <= 1'b1;
    endtask : t_two_plane
    task automatic t_page_read;
        run(32'h0000_0204, 32'h005, 32'h000021);
        chk(st & 32'hFFFF, 32'hE002);
        get(6'h0, 8'h24);
        get(6'h1, 8'h27);
    endtask : t_page_read
    task automatic t_interleave;
        multi_die <= 1'b1;
        run(32'h0000_0110, 32'h010, 32'h000021);
        chk(st & 32'h7, 32'h2);
        get(6'h0, 8'h31);
        multi_die <= 1'b0;
    endtask : t_interleave
    task automatic t_bus;
        axw(`NCAO_REG_CTRL, 32'h0000_0800, r);
        axw(`NCAO_REG_CTRL, 32'h0000_0800, r);
        chk(32'(r), 32'h2);
        axr(8'h1C, 6'h0, d, r);
        chk(d | 32'(r), 32'h2);
        wait_done();
    endtask : t_bus
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (60000) @(posedge aclk);
        mismatches++;
        test_done();
    end
    initial begin
        aresetn = 1'b0;
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        array_rdy = 1'b1;
        cache_rdy = 1'b1;
        multi_die = 1'b0;
        mismatches = 0;
        compares = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_input();
        t_rand_read();
        t_two_plane();
        t_page_read();
        t_interleave();
        t_bus();
        chk(32'(faults), 32'h0);
        test_done();
    end
endmodule : tb_top
